// file: shared/ccp_defs.svh
// Offsets, fields, reset values and mode codes of the capture/compare block
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH
// APB register byte addresses
`define OFF_CHAN1_CONTROL 12'h000
`define OFF_CHAN2_CONTROL 12'h004
`define OFF_CHAN1_VALUE 12'h008
`define OFF_CHAN2_VALUE 12'h00c
`define OFF_FLAGS 12'h010
`define OFF_ENABLES 12'h014
`define OFF_TIMER 12'h018
`define OFF_PORT 12'h01c
// Flag register bit positions
`define FLAG_CHAN1_BIT 2
`define FLAG_CHAN2_BIT 0
`define FLAG_TIMER_OVF_BIT 1
// Port register fields
`define PORT_DATA_BIT 0
`define PORT_DIR_BIT 1
// Mode select codes
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLR 4'h9
`define MODE_CMP_SOFT 4'ha
`define MODE_CMP_SPECIAL 4'hb
`define MODE_CMP_TOGGLE 4'h2
// Prescale terminal counts
`define PRESCALE_4_LAST 4'h3
`define PRESCALE_16_LAST 4'hf
// Reset values
`define RST_CONTROL 4'h0
`define RST_VALUE 16'h0000
`define RST_DIR 1'b1
`endif

// file: shared/ccp_pkg.sv
// Types shared by the capture/compare block
`default_nettype none
package ccp_pkg;
  // Decoded channel behaviour
  typedef enum logic [2:0] {
    act_off, act_capture, act_set, act_clear, act_toggle, act_soft, act_special
  } chan_action_t;
  // Per-channel pin signals
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;
endpackage : ccp_pkg
`default_nettype wire

// file: rtl/capture_compare_channels.sv
// Capture/compare channels beside a 16-bit reference timer, with APB registers
// How it works
// - Capture copies full timer into channel 1
// - Mode picks falling, rising, 4th, 16th edge
// - Capture sets channel 1 flag; software clears
// - Newer capture overwrites unread value
// - Driven pin level can cause capture
// - Mode change may raise false event
// - Prescaler cleared when off or not capture
// - Prescaler switch keeps count uncleared
// - Compare value constantly against timer
// - Match sets, clears, toggles or keeps pin
// - Match flag set with pin action
// - Cleared control forces compare latch low
// - Software mode raises event only, pin untouched
// - Channel 1 trigger resets timer
// - Channel 2 trigger resets timer, starts conversion
// - Channel 2 trigger never sets overflow flag
`include "ccp_defs.svh"
`default_nettype none
module capture_compare_channels
  import ccp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chan1_pin_in,
  output logic chan1_pin_out,
  output logic chan1_pin_oe,
  output logic chan2_pin_out,
  output logic chan2_pin_oe,
  input wire logic adc_enabled,
  output logic adc_start,
  output logic chan1_event,
  output logic chan2_event
);

  // ==========================================================
  // Decoding helpers
  // ==========================================================
  // Mode code to behaviour; used for both channels
  function automatic chan_action_t decode_mode(input logic [3:0] m);
    chan_action_t a;
    a = act_off;
    unique case (m)
      `MODE_CAP_FALL, `MODE_CAP_RISE, `MODE_CAP_RISE4, `MODE_CAP_RISE16: a = act_capture;
      `MODE_CMP_SET: a = act_set;
      `MODE_CMP_CLR: a = act_clear;
      `MODE_CMP_TOGGLE: a = act_toggle;
      `MODE_CMP_SOFT: a = act_soft;
      `MODE_CMP_SPECIAL: a = act_special;
      default: a = act_off;
    endcase
    return a;
  endfunction : decode_mode

  // ==========================================================
  // Registers and state
  // ==========================================================
  logic [3:0] chan1_control_r; // Channel 1 mode select
  logic [3:0] chan2_control_r; // Channel 2 mode select
  logic [15:0] chan1_value_r; // Channel 1 capture/compare value
  logic [15:0] chan2_value_r; // Channel 2 compare value
  logic [15:0] timer_r; // Reference timer
  logic chan1_flag_r; // Channel 1 event flag
  logic chan2_flag_r; // Channel 2 event flag
  logic timer_ovf_flag_r; // Timer overflow flag
  logic chan1_enable_r; // Channel 1 event enable
  logic chan2_enable_r; // Channel 2 event enable
  logic port_data_r; // General port data latch for channel 1 pin
  logic port_dir_r; // 1 = input, as after reset
  logic cmp1_latch_r; // Compare output latches, apart from port latch
  logic cmp2_latch_r;
  logic [3:0] prescale_r; // Capture prescaler counter
  logic sync1_r; // Synchroniser, first stage
  logic sync2_r; // Synchroniser, second stage
  logic pin_prev_r; // Previous synchronised level
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic adc_start_r;
  logic chan1_event_r;
  logic chan2_event_r;
  logic chan1_out_r;
  logic chan1_oe_r;
  logic chan2_out_r;
  logic chan2_oe_r;

  chan_action_t act1;
  chan_action_t act2;
  logic rise;
  logic fall;
  logic cap_hit;
  logic match1;
  logic match2;
  logic wr;
  logic rd_setup;
  logic trig_reset;
  logic pin_level;

  assign act1 = decode_mode(chan1_control_r);
  assign act2 = decode_mode(chan2_control_r);
  // Access phase write; the answer comes in the same cycle
  assign wr = psel && penable && pwrite && pready_r;
  assign rd_setup = psel && !penable && !pwrite;

  // ==========================================================
  // Capture input path
  // ==========================================================
  // driven pin
  // When the pin is an output the driven level is what the pin shows
  assign pin_level = chan1_oe_r ? chan1_out_r : chan1_pin_in;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      sync1_r <= pin_level;
      sync2_r <= sync1_r;
      pin_prev_r <= sync2_r;
    end
  end

  assign rise = sync2_r && !pin_prev_r;
  assign fall = !sync2_r && pin_prev_r;

  always_comb begin
    cap_hit = 1'b0;
    unique case (chan1_control_r)
      `MODE_CAP_FALL: cap_hit = fall;
      `MODE_CAP_RISE: cap_hit = rise;
      `MODE_CAP_RISE4: cap_hit = rise && ({2'b00, prescale_r[1:0]} == `PRESCALE_4_LAST);
      `MODE_CAP_RISE16: cap_hit = rise && (prescale_r == `PRESCALE_16_LAST);
      default: cap_hit = 1'b0;
    endcase
  end

  // Prescaler counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_r <= 4'h0;
    end else if (act1 != act_capture) begin
      prescale_r <= 4'h0;
    end else if (rise) begin
      // count kept across switch
      // A hop from 1:16 to 1:4 keeps the low bits, so first capture may come early
      prescale_r <= prescale_r + 4'h1;
    end
  end

  // ==========================================================
  // Compare and timer
  // ==========================================================
  // constant compare
  assign match1 = (chan1_value_r == timer_r) && (act1 != act_capture) && (act1 != act_off);
  assign match2 = (chan2_value_r == timer_r) && (act2 != act_capture) && (act2 != act_off);
  assign trig_reset = (match1 && act1 == act_special) || (match2 && act2 == act_special);

  // Reference timer; software write wins, else trigger reset, else count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_r <= `RST_VALUE;
    end else if (wr && paddr == `OFF_TIMER) begin
      timer_r <= pwdata[15:0];
    end else if (trig_reset) begin
      timer_r <= `RST_VALUE;
    end else begin
      timer_r <= timer_r + 16'h0001;
    end
  end

  // ==========================================================
  // Control and value registers
  // ==========================================================
  // Channel control and enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan1_control_r <= `RST_CONTROL;
      chan2_control_r <= `RST_CONTROL;
      chan1_enable_r <= 1'b0;
      chan2_enable_r <= 1'b0;
      port_data_r <= 1'b0;
      port_dir_r <= `RST_DIR;
    end else if (wr && pstrb[0]) begin
      if (paddr == `OFF_CHAN1_CONTROL) chan1_control_r <= pwdata[3:0];
      if (paddr == `OFF_CHAN2_CONTROL) chan2_control_r <= pwdata[3:0];
      if (paddr == `OFF_ENABLES) begin
        chan1_enable_r <= pwdata[`FLAG_CHAN1_BIT];
        chan2_enable_r <= pwdata[`FLAG_CHAN2_BIT];
      end
      if (paddr == `OFF_PORT) begin
        port_data_r <= pwdata[`PORT_DATA_BIT];
        port_dir_r <= pwdata[`PORT_DIR_BIT];
      end
    end
  end

  // Channel 1 value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan1_value_r <= `RST_VALUE;
    end else if (act1 == act_capture && cap_hit) begin
      chan1_value_r <= timer_r;
    end else if (wr && paddr == `OFF_CHAN1_VALUE) begin
      chan1_value_r <= pwdata[15:0];
    end
  end

  // Channel 2 value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan2_value_r <= `RST_VALUE;
    end else if (wr && paddr == `OFF_CHAN2_VALUE) begin
      chan2_value_r <= pwdata[15:0];
    end
  end

  // ==========================================================
  // Event flags
  // ==========================================================
  // Hardware set beats software clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan1_flag_r <= 1'b0;
      chan2_flag_r <= 1'b0;
      timer_ovf_flag_r <= 1'b0;
    end else begin
      if ((act1 == act_capture && cap_hit) || match1) begin
        chan1_flag_r <= 1'b1;
      end else if (wr && paddr == `OFF_FLAGS && !pwdata[`FLAG_CHAN1_BIT]) begin
        chan1_flag_r <= 1'b0;
      end
      if (match2) begin
        chan2_flag_r <= 1'b1;
      end else if (wr && paddr == `OFF_FLAGS && !pwdata[`FLAG_CHAN2_BIT]) begin
        chan2_flag_r <= 1'b0;
      end
      // no overflow on trigger
      // Only a natural wrap sets it; a trigger reset is not a wrap
      if (timer_r == 16'hffff && !trig_reset && !(wr && paddr == `OFF_TIMER)) begin
        timer_ovf_flag_r <= 1'b1;
      end else if (wr && paddr == `OFF_FLAGS && !pwdata[`FLAG_TIMER_OVF_BIT]) begin
        timer_ovf_flag_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Compare output latches
  // ==========================================================
  // pin action on match
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp1_latch_r <= 1'b0;
      cmp2_latch_r <= 1'b0;
    end else begin
      if (chan1_control_r == `MODE_OFF) cmp1_latch_r <= 1'b0;
      else if (match1 && act1 == act_set) cmp1_latch_r <= 1'b1;
      else if (match1 && act1 == act_clear) cmp1_latch_r <= 1'b0;
      else if (match1 && act1 == act_toggle) cmp1_latch_r <= !cmp1_latch_r;
      if (chan2_control_r == `MODE_OFF) cmp2_latch_r <= 1'b0;
      else if (match2 && act2 == act_set) cmp2_latch_r <= 1'b1;
      else if (match2 && act2 == act_clear) cmp2_latch_r <= 1'b0;
      else if (match2 && act2 == act_toggle) cmp2_latch_r <= !cmp2_latch_r;
    end
  end

  // Pin drivers; channel 1 level from compare latch in compare modes, else port latch; channel 2 driven only in compare modes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan1_out_r <= 1'b0;
      chan1_oe_r <= 1'b0;
      chan2_out_r <= 1'b0;
      chan2_oe_r <= 1'b0;
    end else begin
      // Channel 1 direction is software's job, so the port bit gates its driver
      chan1_oe_r <= !port_dir_r;
      chan1_out_r <= (act1 == act_capture || act1 == act_off) ? port_data_r : cmp1_latch_r;
      chan2_oe_r <= (act2 != act_off) && (act2 != act_capture);
      chan2_out_r <= cmp2_latch_r;
    end
  end

  // ==========================================================
  // Event outputs
  // ==========================================================
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_start_r <= 1'b0;
      chan1_event_r <= 1'b0;
      chan2_event_r <= 1'b0;
    end else begin
      adc_start_r <= match2 && act2 == act_special && adc_enabled;
      chan1_event_r <= chan1_flag_r && chan1_enable_r;
      chan2_event_r <= chan2_flag_r && chan2_enable_r;
    end
  end

  // ==========================================================
  // APB slave
  // ==========================================================
  // Read data captured in setup, answered with pready in access phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && (paddr > `OFF_PORT || paddr[1:0] != 2'b00);
      prdata_r <= 32'h0000_0000;
      if (rd_setup) begin
        unique case (paddr)
          `OFF_CHAN1_CONTROL: prdata_r <= {28'h0000000, chan1_control_r};
          `OFF_CHAN2_CONTROL: prdata_r <= {28'h0000000, chan2_control_r};
          `OFF_CHAN1_VALUE: prdata_r <= {16'h0000, chan1_value_r};
          `OFF_CHAN2_VALUE: prdata_r <= {16'h0000, chan2_value_r};
          `OFF_FLAGS: prdata_r <= {29'h0000000, chan1_flag_r, timer_ovf_flag_r, chan2_flag_r};
          `OFF_ENABLES: prdata_r <= {29'h0000000, chan1_enable_r, 1'b0, chan2_enable_r};
          `OFF_TIMER: prdata_r <= {16'h0000, timer_r};
          `OFF_PORT: prdata_r <= {30'h00000000, port_dir_r, port_data_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign adc_start = adc_start_r;
  assign chan1_event = chan1_event_r;
  assign chan2_event = chan2_event_r;
  assign chan1_pin_out = chan1_out_r;
  assign chan1_pin_oe = chan1_oe_r;
  assign chan2_pin_out = chan2_out_r;
  assign chan2_pin_oe = chan2_oe_r;

endmodule : capture_compare_channels
`default_nettype wire

// file: test/ccp_checker.sv
// Port checks for the capture/compare block
`include "ccp_defs.svh"
`default_nettype none
module ccp_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chan1_pin_oe,
  input wire logic chan2_pin_out,
  input wire logic chan2_pin_oe,
  input wire logic adc_enabled,
  input wire logic adc_start
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Bus answer
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic acc; // Completed transfer
  assign acc = psel && penable && pready;
  property p_ready_access; psel && !penable |=> pready; endproperty
  a_ready_access: assert property (p_ready_access) else $error("no answer in access");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_err_unmapped; acc && paddr > 12'h01c |-> pslverr; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
  property p_err_none;
    acc && paddr <= 12'h01c && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_err_none: assert property (p_err_none) else $error("mapped access refused");
  property p_read_zero; acc && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_read_zero: assert property (p_read_zero) else $error("refused read not zero");
  property p_upper_zero; acc && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_oe_reset; $rose(rst_n) |-> !chan1_pin_oe && !chan2_pin_oe; endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("pin driven after reset");
  // ==========
  // Channel side
  property p_adc_pulse; adc_start |=> !adc_start; endproperty
  a_adc_pulse: assert property (p_adc_pulse) else $error("start pulse too long");
  property p_adc_gate; adc_start |-> $past(adc_enabled) || adc_enabled; endproperty
  a_adc_gate: assert property (p_adc_gate) else $error("start while converter off");
  property p_latch_clear;
    acc && pwrite && paddr == `OFF_CHAN2_CONTROL && pstrb[0] && pwdata[3:0] == 4'h0
      |-> ##[1:3] !chan2_pin_out;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not forced low");
  c_refused: cover property (acc && pslverr);
  c_adc: cover property (adc_start);
  c_pin_low: cover property ($fell(chan2_pin_out) && chan2_pin_oe);
endmodule : ccp_checker
`default_nettype wire

// file: test/pin_partner.sv
// Wire model of the channel 1 pin
`default_nettype none
module pin_partner (
  input wire logic ext_lvl,
  input wire logic drv,
  input wire logic drv_oe,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Pad level
  // block drives when output
  assign pin = drv_oe ? drv : ext_lvl;
endmodule : pin_partner
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the capture/compare channels
`include "ccp_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccp_pkg::*;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, pin_lvl, pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic p1_out, p1_oe, p2_out, p2_oe, adc_enabled, adc_start, ev1, ev2;
  int fails, compares, cyc, rise, t0, d, adc_n, n0;
  logic [3:0] cm [4] = '{`MODE_CMP_SET, `MODE_CMP_CLR, `MODE_CMP_TOGGLE, `MODE_CMP_TOGGLE};
  logic ce [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  // Count start pulses
  always @(posedge core_clk) if (adc_start === 1'b1) adc_n <= adc_n + 1;
  capture_compare_channels i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan1_pin_in(pin),
    .chan1_pin_out(p1_out), .chan1_pin_oe(p1_oe), .chan2_pin_out(p2_out),
    .chan2_pin_oe(p2_oe), .adc_enabled(adc_enabled), .adc_start(adc_start),
    .chan1_event(ev1), .chan2_event(ev2));
  pin_partner i_pin (.ext_lvl(pin_lvl), .drv(p1_out), .drv_oe(p1_oe), .pin(pin));
  // ==========
  // Tasks
  task automatic summarize();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One transfer, request held until ready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (n >= 16) begin
      fails++;
      summarize();
    end
  endtask : apb
  // Read a flag, then clear all flags
  task automatic flag(input int b, input logic e);
    apb(1'b0, `OFF_FLAGS, 32'h0);
    chk(rd[b], e);
    apb(1'b1, `OFF_FLAGS, 32'h0);
  endtask : flag
  // Pulses long enough to pass the input synchroniser
  task automatic pulse(input int k);
    repeat (k) begin
      pin_lvl <= 1'b1;
      rise = cyc;
      repeat (4) @(posedge core_clk);
      pin_lvl <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask : pulse
  task automatic pre(input int n);
    apb(1'b1, `OFF_FLAGS, 32'h0);
    pulse(n);
    flag(2, 1'b0);
    pulse(1);
    flag(2, 1'b1);
  endtask : pre
  // Timer parked far from the value, then brought just below it
  task automatic cmp(input logic [11:0] c, input logic [3:0] m);
    apb(1'b1, `OFF_TIMER, 32'h0);
    apb(1'b1, c, {28'h0, m});
    apb(1'b1, c + 12'h008, 32'h100);
    apb(1'b1, `OFF_FLAGS, 32'h0);
    apb(1'b1, `OFF_TIMER, 32'hf0);
    repeat (30) @(posedge core_clk);
  endtask : cmp
  // ==========
  // Sequence
  initial begin
    {core_clk, rst_n, psel, penable, pwrite, pin_lvl, adc_enabled} = '0;
    {paddr, pwdata, fails, compares, cyc, adc_n} = '0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, `OFF_PORT, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, 12'h020, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, `OFF_CHAN1_CONTROL, `MODE_CAP_RISE);
    apb(1'b1, `OFF_TIMER, 32'h0);
    t0 = cyc;
    pulse(2);
    apb(1'b0, `OFF_CHAN1_VALUE, 32'h0);
    d = rise - t0;
    chk(rd >= d && rd <= d + 8, 1);
    repeat (20) @(posedge core_clk);
    flag(2, 1'b1);
    flag(2, 1'b0);
    apb(1'b1, `OFF_CHAN1_CONTROL, `MODE_CAP_FALL);
    apb(1'b1, `OFF_FLAGS, 32'h0);
    pin_lvl <= 1'b1;
    repeat (6) @(posedge core_clk);
    flag(2, 1'b0);
    pin_lvl <= 1'b0;
    repeat (6) @(posedge core_clk);
    flag(2, 1'b1);
    apb(1'b1, `OFF_CHAN1_CONTROL, `MODE_OFF);
    apb(1'b1, `OFF_CHAN1_CONTROL, `MODE_CAP_RISE4);
    pulse(2);
    apb(1'b1, `OFF_CHAN1_CONTROL, `MODE_CAP_RISE16);
    pre(13);
    apb(1'b1, `OFF_CHAN1_CONTROL, `MODE_CAP_RISE4);
    pulse(2);
    apb(1'b1, `OFF_CHAN1_CONTROL, `MODE_OFF);
    apb(1'b1, `OFF_CHAN1_CONTROL, `MODE_CAP_RISE4);
    pre(3);
    apb(1'b1, `OFF_CHAN1_CONTROL, `MODE_OFF);
    apb(1'b1, `OFF_CHAN1_CONTROL, `MODE_CAP_RISE16);
    pre(15);
    apb(1'b1, `OFF_PORT, 32'h0);
    apb(1'b1, `OFF_CHAN1_CONTROL, `MODE_CAP_RISE);
    apb(1'b1, `OFF_FLAGS, 32'h0);
    apb(1'b1, `OFF_PORT, 32'h1);
    repeat (6) @(posedge core_clk);
    flag(2, 1'b1);
    chk(p1_oe, 1'b1);
    chk(p1_out, 1'b1);
    for (int i = 0; i < 4; i++) begin
      cmp(`OFF_CHAN2_CONTROL, cm[i]);
      chk(p2_out, ce[i]);
      flag(0, 1'b1);
    end
    chk(p2_oe, 1'b1);
    cmp(`OFF_CHAN2_CONTROL, `MODE_CMP_SET);
    apb(1'b1, `OFF_ENABLES, 32'h1);
    cmp(`OFF_CHAN2_CONTROL, `MODE_CMP_SOFT);
    chk(p2_out, 1'b1);
    chk(ev2, 1'b1);
    apb(1'b1, `OFF_ENABLES, 32'h0);
    cmp(`OFF_CHAN2_CONTROL, `MODE_CMP_SOFT);
    chk(ev2, 1'b0);
    apb(1'b1, `OFF_CHAN2_CONTROL, `MODE_OFF);
    repeat (3) @(posedge core_clk);
    chk(p2_out, 1'b0);
    adc_enabled <= 1'b1;
    n0 = adc_n;
    cmp(`OFF_CHAN2_CONTROL, `MODE_CMP_SPECIAL);
    chk(adc_n, n0 + 1);
    apb(1'b0, `OFF_TIMER, 32'h0);
    chk(rd < 32'h40, 1);
    flag(1, 1'b0);
    // Natural wrap must still set the overflow flag
    apb(1'b1, `OFF_TIMER, 32'hfff0);
    repeat (20) @(posedge core_clk);
    flag(1, 1'b1);
    adc_enabled <= 1'b0;
    cmp(`OFF_CHAN2_CONTROL, `MODE_CMP_SPECIAL);
    chk(adc_n, n0 + 1);
    apb(1'b1, `OFF_CHAN2_CONTROL, `MODE_OFF);
    cmp(`OFF_CHAN1_CONTROL, `MODE_CMP_SPECIAL);
    apb(1'b0, `OFF_TIMER, 32'h0);
    chk(rd < 32'h40, 1);
    // Event output follows flag one cycle after enable
    apb(1'b1, `OFF_ENABLES, 32'h4);
    @(posedge core_clk);
    chk(ev1, 1'b1);
    flag(2, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, `OFF_CHAN1_CONTROL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `OFF_PORT, 32'h0);
    chk(rd, 32'h2);
    chk(ev1, 1'b0);
    summarize();
  end
endmodule : tb
bind capture_compare_channels ccp_checker i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chan1_pin_oe(chan1_pin_oe), .chan2_pin_out(chan2_pin_out), .chan2_pin_oe(chan2_pin_oe),
  .adc_enabled(adc_enabled), .adc_start(adc_start));
`default_nettype wire
